// ### hw/ref_ladder_control.v
/*
  Digital control of a 32-level ratiometric reference ladder: two 8-bit
  control registers, decoded switch controls for the analog ladder and
  the override of the reference output pin.
  Assumes a synchronous register port with read data one cycle later,
  pin inputs synchronous to REF_CLK_I, and an analog ladder outside.
*/
// Local design decisions: the register offsets and strobed register access.
// Function
// - 32 levels chosen by 5-bit level code.
// - Output is linear tap of level code.
// - Low-power side keeps positive or negative source.
// - Pin output enable routes reference to pin.
// - Routed pin disables digital driver and input.
// - Digital read of routed pin returns 0.
// - Ladder enable bit turns converter on.
// - Positive source select decodes three sources.
// - Negative source select: external or ground.
// - Unimplemented bits ignore writes, read zero.
// - Level code in bits 4-0, read/write.
// - Sleep wake keeps first register unchanged.
// - Reset clears all implemented bits.
`timescale 1ns/1ps
`include "ref_ladder_defs.vh"

module ref_ladder_control
  #(
  parameter LEVEL_W = `LEVEL_WIDTH
  )
  (
  // Clock and reset.
  input  wire               REF_CLK_I,
  input  wire               RSTN_I,
  // Register port.
  input  wire [1:0]         ADDR_I,
  input  wire [7:0]         WDATA_I,
  input  wire               WR_I,
  input  wire               RD_I,
  output reg  [7:0]         RDATA_O,
  // Ladder switch controls.
  output reg                LADDER_ENABLE_O,
  output reg                POS_SRC_CONNECT_O,
  output reg                NEG_SRC_CONNECT_O,
  output reg                POS_SEL_SUPPLY_O,
  output reg                POS_SEL_EXT_REF_O,
  output reg                POS_SEL_FIXED_REF_O,
  output reg                NEG_SEL_EXT_REF_O,
  output reg  [LEVEL_W-1:0] LEVEL_CODE_O,
  output reg  [LEVEL_W:0]   TAP_SELECT_O,
  // Output pin: routing switch, digital pin override.
  output reg                REF_OUT_PIN_ROUTE_O,
  input  wire               PORT_DRIVE_OE_I,
  input  wire               PORT_DRIVE_DATA_I,
  input  wire               REF_OUT_PIN_IN_I,
  output reg                REF_OUT_PIN_OE_O,
  output reg                REF_OUT_PIN_O,
  output reg                PIN_READ_O
  );

  // Register storage; only implemented bits are kept.
  reg  [7:0]         control_main;
  reg  [LEVEL_W-1:0] level_code;
  wire [7:0]         next_control_main;
  wire [LEVEL_W-1:0] next_level_code;
  wire [7:0]         read_mux;
  wire [1:0]         pos_sel;
  wire               route;
  wire               ladder_on;
  wire               low_power_side;
  wire               neg_ext_sel;
  wire               clamp_high;
  reg                next_pos_connect;
  reg                next_neg_connect;
  reg                next_sel_supply;
  reg                next_sel_ext_ref;
  reg                next_sel_fixed_ref;
  reg  [LEVEL_W:0]   next_tap;
  reg                next_pin_oe;
  reg                next_pin_data;
  reg                next_pin_read;

  // Timing overview for anyone wiring this block into a system.
  // A write strobe lands in the register at the edge that samples it.
  // Every ladder control output then follows one edge later, so the
  // analog switches see the new setting two edges after the strobe.
  // A read strobe returns data in the following cycle only; the read
  // port goes back to zero afterwards, so a late sample reads zero.
  // The pin override also costs one cycle: the port drive and pad level
  // are registered here, which keeps every output straight from a flop.
  // The trade is a single cycle of latency on the pin against clean,
  // glitch-free levels at the pad and at the analog switches.
  // There is no sleep input. Sleep and wake therefore cannot disturb any
  // stored setting; only the reset input clears the registers.
  // Software is expected to clear the ladder enable before sleep to
  // save current; the block itself does not enforce that.

  // Writes keep only implemented bits, so reserved ones stay zero.
  assign next_control_main = WDATA_I & `MASK_CONTROL_MAIN;
  assign next_level_code   = WDATA_I[LEVEL_W-1:0];

  // Reset is the only thing that clears the registers; there is no sleep
  // input, so a wake from sleep cannot disturb the stored settings.
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      control_main <= `RESET_CONTROL_MAIN;
      level_code   <= {LEVEL_W{1'b0}};
    end
    else if (WR_I)
    begin
      if (ADDR_I == `ADDR_CONTROL_MAIN)
      begin
        control_main <= next_control_main;
      end
      else if (ADDR_I == `ADDR_LEVEL_SELECT)
      begin
        level_code <= next_level_code;
      end
    end
  end

  // Read decode; unmapped addresses and reserved bits read as zero.
  assign read_mux = (ADDR_I == `ADDR_CONTROL_MAIN) ? (control_main & `MASK_CONTROL_MAIN) :
                    (ADDR_I == `ADDR_LEVEL_SELECT) ? {{(8-LEVEL_W){1'b0}}, level_code} :
                    8'h00;

  assign pos_sel = control_main[`BIT_POS_SEL_HI:`BIT_POS_SEL_LO];
  assign route   = control_main[`BIT_PIN_OUT_ENABLE];

  // Read data stands in the cycle after the strobe only.
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      RDATA_O <= 8'h00;
    end
    else if (RD_I)
    begin
      RDATA_O <= read_mux;
    end
    else
    begin
      RDATA_O <= 8'h00;
    end
  end

  // Decoded views of the stored control fields, named for the switches
  // that they drive, so the output logic below reads like the ladder.
  assign ladder_on      = control_main[`BIT_LADDER_ENABLE];
  assign low_power_side = control_main[`BIT_LOW_POWER_SIDE];
  assign neg_ext_sel    = control_main[`BIT_NEG_SOURCE_SEL];

  // Clamp-high condition: converter off, positive end kept and the
  // all-ones code written. Only then is the very top of the ladder tapped.
  assign clamp_high = ~ladder_on & low_power_side & (level_code == `LEVEL_ALL_ONES);

  // Ladder end switches. With the converter on both ends stay connected;
  // with it off the low-power side bit keeps exactly one end, so the
  // ladder carries no current while it is idle.
  always @*
  begin
    next_pos_connect = 1'b0;
    next_neg_connect = 1'b0;
    if (ladder_on)
    begin
      next_pos_connect = 1'b1;
      next_neg_connect = 1'b1;
    end
    else if (low_power_side)
    begin
      next_pos_connect = 1'b1;
    end
    else
    begin
      next_neg_connect = 1'b1;
    end
  end

  // Positive source decode, one-hot. The reserved code selects no source
  // rather than two at once, which would short two references together.
  always @*
  begin
    next_sel_supply    = 1'b0;
    next_sel_ext_ref   = 1'b0;
    next_sel_fixed_ref = 1'b0;
    case (pos_sel)
      `POS_SEL_SUPPLY:
      begin
        next_sel_supply = 1'b1;
      end
      `POS_SEL_EXT_REF:
      begin
        next_sel_ext_ref = 1'b1;
      end
      `POS_SEL_FIXED_REF:
      begin
        next_sel_fixed_ref = 1'b1;
      end
      default:
      begin
        next_sel_supply    = 1'b0;
        next_sel_ext_ref   = 1'b0;
        next_sel_fixed_ref = 1'b0;
      end
    endcase
  end

  // Tap index. It equals the code, so the output is linear in it; the
  // clamp-high setting reaches past the last resistor to the full top.
  always @*
  begin
    if (clamp_high)
    begin
      next_tap = `LEVEL_COUNT;
    end
    else
    begin
      next_tap = {1'b0, level_code};
    end
  end

  // Pin override. Routing the reference takes the pin away from the port:
  // no digital drive and a read value of zero. A user who routes the
  // reference must not expect the port's own output to reach the pin.
  always @*
  begin
    next_pin_oe   = PORT_DRIVE_OE_I;
    next_pin_data = PORT_DRIVE_DATA_I;
    next_pin_read = REF_OUT_PIN_IN_I;
    if (route)
    begin
      next_pin_oe   = 1'b0;
      next_pin_data = 1'b0;
      next_pin_read = 1'b0;
    end
  end

  // Ladder controls are registered from the control registers, so they
  // follow a write by one cycle; the analog side sees glitch-free levels.
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      LADDER_ENABLE_O     <= 1'b0;
      POS_SRC_CONNECT_O   <= 1'b0;
      NEG_SRC_CONNECT_O   <= 1'b0;
      POS_SEL_SUPPLY_O    <= 1'b0;
      POS_SEL_EXT_REF_O   <= 1'b0;
      POS_SEL_FIXED_REF_O <= 1'b0;
      NEG_SEL_EXT_REF_O   <= 1'b0;
      LEVEL_CODE_O        <= {LEVEL_W{1'b0}};
      TAP_SELECT_O        <= {(LEVEL_W+1){1'b0}};
      REF_OUT_PIN_ROUTE_O <= 1'b0;
    end
    else
    begin
      LADDER_ENABLE_O     <= ladder_on;
      POS_SRC_CONNECT_O   <= next_pos_connect;
      NEG_SRC_CONNECT_O   <= next_neg_connect;
      POS_SEL_SUPPLY_O    <= next_sel_supply;
      POS_SEL_EXT_REF_O   <= next_sel_ext_ref;
      POS_SEL_FIXED_REF_O <= next_sel_fixed_ref;
      NEG_SEL_EXT_REF_O   <= neg_ext_sel;
      LEVEL_CODE_O        <= level_code;
      TAP_SELECT_O        <= next_tap;
      REF_OUT_PIN_ROUTE_O <= route;
    end
  end

  // Pin outputs are registered too; the override therefore takes effect
  // in the same cycle as the routing switch closes.
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      REF_OUT_PIN_OE_O <= 1'b0;
      REF_OUT_PIN_O    <= 1'b0;
      PIN_READ_O       <= 1'b0;
    end
    else
    begin
      REF_OUT_PIN_OE_O <= next_pin_oe;
      REF_OUT_PIN_O    <= next_pin_data;
      PIN_READ_O       <= next_pin_read;
    end
  end

endmodule // ref_ladder_control

// ### hw/ref_ladder_defs.vh
/*
  Constants for the reference ladder control block: register offsets,
  field positions, reset values and source select codes.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef REF_LADDER_DEFS_VH
`define REF_LADDER_DEFS_VH

// Register offsets on the plain register port.
`define ADDR_CONTROL_MAIN   2'h0
`define ADDR_LEVEL_SELECT   2'h1

// Field positions in ref_control_main.
`define BIT_LADDER_ENABLE   7
`define BIT_LOW_POWER_SIDE  6
`define BIT_PIN_OUT_ENABLE  5
`define BIT_POS_SEL_HI      3
`define BIT_POS_SEL_LO      2
`define BIT_NEG_SOURCE_SEL  0

// Implemented-bit masks and reset values.
`define MASK_CONTROL_MAIN   8'hed
`define MASK_LEVEL_SELECT   8'h1f
`define RESET_CONTROL_MAIN  8'h00
`define RESET_LEVEL_SELECT  8'h00

// Positive source codes.
`define POS_SEL_SUPPLY      2'h0
`define POS_SEL_EXT_REF     2'h1
`define POS_SEL_FIXED_REF   2'h2
`define POS_SEL_RESERVED    2'h3

// Level code width and level count.
`define LEVEL_WIDTH         5
`define LEVEL_COUNT         6'h20
`define LEVEL_ALL_ONES      5'h1f

`endif

// ### tb/ref_ladder_control_properties.sv
/* Port assertions for ref_ladder_control.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module ref_ladder_props #(parameter LEVEL_W = 5) (
  input wire REF_CLK_I, RSTN_I, WR_I, RD_I, LADDER_ENABLE_O, POS_SRC_CONNECT_O,
  input wire NEG_SRC_CONNECT_O, POS_SEL_SUPPLY_O, POS_SEL_EXT_REF_O, POS_SEL_FIXED_REF_O,
  input wire REF_OUT_PIN_ROUTE_O, REF_OUT_PIN_OE_O, REF_OUT_PIN_O, PIN_READ_O,
  input wire [1:0] ADDR_I,
  input wire [7:0] WDATA_I, RDATA_O,
  input wire [LEVEL_W-1:0] LEVEL_CODE_O,
  input wire [LEVEL_W:0] TAP_SELECT_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // A write lands on one edge and the controls follow on the next.
  sequence wr_main; WR_I && ADDR_I == 2'h0; endsequence
  sequence wr_level; WR_I && ADDR_I == 2'h1; endsequence
  a_enable_follows : assert property (wr_main |-> ##2 LADDER_ENABLE_O == $past(WDATA_I[7], 2))
    else $error("Ladder enable wrong.");
  a_pos_connect : assert property (wr_main |-> ##2 POS_SRC_CONNECT_O == |$past(WDATA_I[7:6], 2))
    else $error("Positive end wrong.");
  a_neg_connect : assert property (wr_main |-> ##2 NEG_SRC_CONNECT_O == ($past(WDATA_I[7:6], 2) != 2'h1))
    else $error("Negative end wrong.");
  a_pos_decode : assert property (wr_main |-> ##2
    {POS_SEL_FIXED_REF_O, POS_SEL_EXT_REF_O, POS_SEL_SUPPLY_O} == 3'h1 << $past(WDATA_I[3:2], 2))
    else $error("Source decode wrong.");
  a_route_follows : assert property (wr_main |-> ##2 REF_OUT_PIN_ROUTE_O == $past(WDATA_I[5], 2))
    else $error("Pin routing wrong.");
  a_level_follows : assert property (wr_level |-> ##2 LEVEL_CODE_O == $past(WDATA_I[LEVEL_W-1:0], 2))
    else $error("Level code wrong.");
  a_reserved_zero : assert property (RD_I |=> (RDATA_O & ($past(ADDR_I) == 2'h0 ? 8'h12 :
    $past(ADDR_I) == 2'h1 ? 8'he0 : 8'hff)) == 8'h00) else $error("Reserved bits read back.");
  a_pin_isolated : assert property (REF_OUT_PIN_ROUTE_O |-> !(REF_OUT_PIN_OE_O | REF_OUT_PIN_O | PIN_READ_O))
    else $error("Pin not isolated.");
  a_tap_clamp : assert property (TAP_SELECT_O == ((!LADDER_ENABLE_O && POS_SRC_CONNECT_O && &LEVEL_CODE_O) ?
    {1'b1, {LEVEL_W{1'b0}}} : {1'b0, LEVEL_CODE_O})) else $error("Tap select wrong.");
endmodule // ref_ladder_props
bind ref_ladder_control ref_ladder_props #(.LEVEL_W(LEVEL_W)) props (.*);

// ### tb/tb_ref_ladder_control.sv
/* Self-checking bench for ref_ladder_control with random traffic.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module tb_ref_ladder_control;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [2:0] pin = 0, pin_last = 0;
  logic [7:0] m [4];
  int bad_count = 0, comparisons = 0, i;
  wire [7:0] rdata;
  wire le, pc, nc, ps, pe, pf, ns, rt, oe, po, pr;
  wire [4:0] lv;
  wire [5:0] tap;
  wire [18:0] ctl_seen = {le, pc, nc, ps, pe, pf, ns, lv, tap, rt};
  ref_ladder_control uut (.REF_CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .LADDER_ENABLE_O(le), .POS_SRC_CONNECT_O(pc),
    .NEG_SRC_CONNECT_O(nc), .POS_SEL_SUPPLY_O(ps), .POS_SEL_EXT_REF_O(pe),
    .POS_SEL_FIXED_REF_O(pf), .NEG_SEL_EXT_REF_O(ns), .LEVEL_CODE_O(lv), .TAP_SELECT_O(tap),
    .REF_OUT_PIN_ROUTE_O(rt), .PORT_DRIVE_OE_I(pin[2]), .PORT_DRIVE_DATA_I(pin[1]),
    .REF_OUT_PIN_IN_I(pin[0]), .REF_OUT_PIN_OE_O(oe), .REF_OUT_PIN_O(po), .PIN_READ_O(pr));
  // Clock at 100 MHz.
  initial forever #5 clk = ~clk;
  // Pin inputs change at random; the set seen at each edge is kept.
  always @(posedge clk)
  begin
    pin_last <= pin;
    pin <= rst_n ? 3'($urandom) : 3'h0;
  end
  function automatic logic [18:0] ctl(input logic [7:0] c, input logic [4:0] l);
    ctl = {c[7], |c[7:6], c[7:6] != 2'h1, c[3:2] == 2'h0, c[3:2] == 2'h1, c[3:2] == 2'h2, c[0],
      l, (c[7:6] == 2'h1 && l == 5'h1f) ? 6'h20 : {1'b0, l}, c[5]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task write_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1;
    @(posedge clk);
    wr_s <= 0;
    @(posedge clk);
    #1 m[a] = d & (a == 0 ? 8'hed : a == 1 ? 8'h1f : 8'h00);
  endtask
  task read_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1;
    @(posedge clk);
    rd_s <= 0;
    #1 chk(rdata, m[a]);
  endtask
  task chkall;
    chk(ctl_seen, ctl(m[0], m[1][4:0]));
    chk({oe, po, pr}, pin_last & {3{~m[0][5]}});
    read_reg(0);
    read_reg(1);
    read_reg(2'($urandom));
  endtask
  task print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence; a reset mid-run must clear everything again.
  initial
  begin
    void'($urandom(67684));
    m = '{default: 8'h00};
    repeat (16) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    #1 chkall;
    for (i = 0; i < 60; i++)
    begin
      write_reg(2'($urandom), 8'($urandom));
      chkall;
    end
    for (i = 0; i < 4; i++)
    begin
      write_reg(0, 8'h20 | 8'(i << 2));
      chkall;
    end
    write_reg(0, 8'h48);
    write_reg(1, 8'hff);
    chkall;
    write_reg(0, 8'h00);
    write_reg(1, 8'h00);
    chkall;
    write_reg(0, 8'h2c);
    chkall;
    write_reg(0, 8'hff);
    @(posedge clk);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    m = '{default: 8'h00};
    repeat (2) @(posedge clk);
    #1 chkall;
    print_verdict;
  end
  // Watchdog, far beyond the roughly 650 cycles the run needs.
  initial
  begin
    #50000;
    bad_count++;
    print_verdict;
  end
endmodule // tb_ref_ladder_control
